/* File: hdl/microcoded_cpu_control_datapath.sv */
// microprogrammed control processor with 16-bit sliced datapath
`default_nettype none
module microcoded_cpu_control_datapath
    import ucpu_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic                 board_fast_input_clock,
    input  wire logic                 data_channel_req,
    input  wire logic                 io_interrupt_req,
    input  wire logic                 refresh_nmi_req,
    input  wire logic                 console_mode,
    input  wire logic                 battery_backup,
    input  wire logic                 refresh_row_step,
    input  wire logic                 io_ready,
    input  wire logic [WORD_W-1:0]    memory_read_bus,
    input  wire logic [WORD_W-1:0]    console_read_bus,
    input  wire logic                 cs_load_en,
    input  wire logic [CS_ADDR_W-1:0] cs_load_addr,
    input  wire logic [HALF_W-1:0]    cs_load_data,
    output logic                      fast_system_clock,
    output logic                      microcycle_phase_a_clock,
    output logic                      microcycle_phase_b_clock,
    output logic [MADDR_W-1:0]        memory_address_bus,
    output logic [WORD_W-1:0]         write_data_bus,
    output logic [WORD_W-1:0]         alu_result_bus,
    output logic [UADDR_W-1:0]        micro_address,
    output logic [HALF_W-1:0]         micro_register_a,
    output logic [HALF_W-1:0]         micro_register_b,
    output logic [WORD_W-1:0]         instruction,
    output logic [WORD_W-1:0]         read_data
);
    // the fast pin is async to clk: two stages before use
    logic fast_s1_r, fast_s2_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_s1_r <= 1'b0;
            fast_s2_r <= 1'b0;
        end else begin
            fast_s1_r <= board_fast_input_clock;
            fast_s2_r <= fast_s1_r;
        end
    end
    // inverted copy of the synchronised fast clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fast_system_clock <= 1'b0;
        end else begin
            fast_system_clock <= ~fast_s2_r;
        end
    end

    // phase counter: the fast pin is far above clk so the microcycle runs on clk
    logic [PCNT_W-1:0] pcnt_r;
    phase_t phase_r;
    logic   phase_end;
    assign phase_end = (pcnt_r == PHASE_LAST);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pcnt_r  <= '0;
            phase_r <= PH_A;
        end else if (phase_end) begin
            pcnt_r  <= '0;
            phase_r <= (phase_r == PH_A) ? PH_B : PH_A;
        end else begin
            pcnt_r <= pcnt_r + PCNT_W'(1);
        end
    end
    // phase clocks follow the phase register's next value: pins and half select never disagree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            microcycle_phase_a_clock <= 1'b1;
            microcycle_phase_b_clock <= 1'b0;
        end else begin
            microcycle_phase_a_clock <= (phase_r == PH_A) ^ phase_end;
            microcycle_phase_b_clock <= (phase_r != PH_A) ^ phase_end;
        end
    end

    // control store: three 8-bit roms of 512 words, half a at even, half b at odd
    logic [ROM_W-1:0] rom_mem [ROMS_PER_PAGE][CS_DEPTH];
    logic [CS_ADDR_W-1:0] cs_addr;
    logic [HALF_W-1:0]    control_store_bus;
    logic [UADDR_W-1:0]   uaddr_r;
    assign cs_addr = {uaddr_r, (phase_r != PH_A)};
    genvar g;
    generate
        for (g = 0; g < ROMS_PER_PAGE; g++) begin : g_rom
            // loadable so a bench can place microcode; normally written once
            always_ff @(posedge clk) begin
                if (cs_load_en) begin
                    rom_mem[g][cs_load_addr] <= cs_load_data[g*ROM_W +: ROM_W];
                end
            end
            assign control_store_bus[g*ROM_W +: ROM_W] = rom_mem[g][cs_addr];
        end
    endgenerate

    // alc decode: instruction bits counted from msb 0
    function automatic logic [9:0] alc_decode(input logic [WORD_W-1:0] ir);
        logic [4:0] f;
        f = ir[WORD_W-1-IR_ALC_LO -: 5];
        alc_decode = {f, ir[WORD_W-1-IR_ALC_X], f[3:0] ^ {4{ir[WORD_W-1-IR_ALC_X]}}};
    endfunction

    // microinstruction registers load at the end of each phase
    logic alc_active;
    assign alc_active = micro_register_b[B_ALC_BIT];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            micro_register_a <= UI_NOP;
        end else if (phase_end && phase_r == PH_A) begin
            micro_register_a <= control_store_bus;
            if (alc_active) begin
                micro_register_a[HALF_W-1 -: 10] <= alc_decode(instruction);
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            micro_register_b <= UI_NOP;
        end else if (phase_end && phase_r == PH_B) begin
            micro_register_b <= control_store_bus;
        end
    end

    // datapath fields steered by register a
    logic [SEL_W-1:0]  port_a_select, port_b_select;
    logic [8:0]        alu_op;
    logic              rf_we, r_mux;
    logic [1:0]        s_mux;
    dst_t              dst;
    assign port_a_select = micro_register_a[A_SELA_LO +: SEL_W];
    assign port_b_select = micro_register_a[A_SELB_LO +: SEL_W];
    assign rf_we  = micro_register_a[A_WE_BIT];
    assign r_mux  = micro_register_a[A_RMUX_BIT];
    assign s_mux  = micro_register_a[A_SMUX_LO +: 2];
    assign dst    = dst_t'(micro_register_a[A_DST_LO +: 2]);
    assign alu_op = micro_register_a[A_OP_HI:A_OP_LO];

    // register file and operand muxes
    logic [WORD_W-1:0] rf_mem [RF_DEPTH];
    logic [WORD_W-1:0] rd_a, rd_b, r_op, s_op;
    logic [WORD_W-1:0] spad_mem [RF_DEPTH];
    logic [WORD_W-1:0] spad_rd;
    assign rd_a = rf_mem[port_a_select];
    assign rd_b = rf_mem[port_b_select];
    assign r_op = r_mux ? read_data : rd_a;
    always_comb begin
        case (s_mux)
            2'b00:   s_op = rd_b;
            2'b01:   s_op = rd_a;
            2'b10:   s_op = spad_rd;
            default: s_op = rd_b;
        endcase
    end

    // four slices with group propagate/generate into lookahead
    logic [SLICES:0]       cin;
    logic [SLICES-1:0]     gp, gg;
    logic [WORD_W-1:0]     alu_y;
    logic [WORD_W-1:0]     sx;
    assign sx     = alu_op[0] ? ~s_op : s_op;
    assign cin[0] = alu_op[1];
    generate
        for (g = 0; g < SLICES; g++) begin : g_slice
            logic [SLICE_W-1:0] a4, b4, p4, g4;
            logic [SLICE_W:0]   c4;
            assign a4 = r_op[g*SLICE_W +: SLICE_W];
            assign b4 = sx[g*SLICE_W +: SLICE_W];
            assign p4 = a4 ^ b4;
            assign g4 = a4 & b4;
            assign c4[0] = cin[g];
            for (genvar k = 0; k < SLICE_W; k++) begin : g_bit
                assign c4[k+1] = g4[k] | (p4[k] & c4[k]);
            end
            assign gp[g] = &p4;
            assign gg[g] = c4[SLICE_W] & (~cin[g] | ~gp[g]); // carry out with no carry in
            assign cin[g+1] = gg[g] | (gp[g] & cin[g]);
            always_comb begin
                case (alu_op[4:2])
                    3'd0:    alu_y[g*SLICE_W +: SLICE_W] = p4 ^ c4[SLICE_W-1:0];
                    3'd1:    alu_y[g*SLICE_W +: SLICE_W] = a4 & b4;
                    3'd2:    alu_y[g*SLICE_W +: SLICE_W] = a4 | b4;
                    3'd3:    alu_y[g*SLICE_W +: SLICE_W] = a4 ^ b4;
                    3'd4:    alu_y[g*SLICE_W +: SLICE_W] = a4;
                    3'd5:    alu_y[g*SLICE_W +: SLICE_W] = b4;
                    default: alu_y[g*SLICE_W +: SLICE_W] = ~a4;
                endcase
            end
        end
    endgenerate

    // result bus register and write-backs at the close of phase b
    logic step_b;
    logic alu_carry_r;
    assign step_b = phase_end && (phase_r == PH_B);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            alu_result_bus <= '0;
            alu_carry_r    <= 1'b0;
        end else if (step_b) begin
            alu_result_bus <= alu_y;
            alu_carry_r    <= cin[SLICES];
        end
    end
    always_ff @(posedge clk) begin
        if (step_b && rf_we) begin
            rf_mem[port_b_select] <= alu_y;
        end
    end
    // scratchpad addressed by the low bits of the address register
    assign spad_rd = spad_mem[memory_address_bus[SPAD_AW-1:0]];
    always_ff @(posedge clk) begin
        if (step_b && dst == DST_SPAD) begin
            spad_mem[memory_address_bus[SPAD_AW-1:0]] <= alu_y;
        end
    end

    // address register; row part counts while on battery
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memory_address_bus <= '0;
        end else if (battery_backup) begin
            if (refresh_row_step) begin
                memory_address_bus[ROW_W-1:0] <= memory_address_bus[ROW_W-1:0] + ROW_W'(1);
            end
        end else if (step_b && dst == DST_MAR) begin
            memory_address_bus <= alu_y[MADDR_W-1:0];
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_data_bus <= '0;
        end else if (step_b && dst == DST_WDR) begin
            write_data_bus <= alu_y;
        end
    end
    // read data and instruction capture from memory or console
    logic [WORD_W-1:0] fetch_src;
    assign fetch_src = console_mode ? console_read_bus : memory_read_bus;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data <= '0;
        end else if (step_b) begin
            read_data <= fetch_src;
        end
    end

    // test logic picks the next-next address field
    logic test_ok, seq_end;
    always_comb begin
        case (test_t'(micro_register_b[B_TEST_LO +: TEST_W]))
            T_TRUE:    test_ok = 1'b1;
            T_ZERO:    test_ok = (alu_result_bus == '0);
            T_CARRY:   test_ok = alu_carry_r;
            T_NEG:     test_ok = alu_result_bus[WORD_W-1];
            T_CONSOLE: test_ok = console_mode;
            T_IOREADY: test_ok = io_ready;
            T_FALSE:   test_ok = 1'b0;
            default:   test_ok = control_store_bus[0];
        endcase
    end
    logic [UADDR_W-1:0] branch_addr;
    assign branch_addr = test_ok ? micro_register_b[B_TRUE_LO +: UADDR_W]
                                 : micro_register_b[B_FALSE_LO +: UADDR_W];
    assign seq_end = (branch_addr == UA_END);

    // start address: refresh beats data channel beats interrupt beats instruction
    function automatic logic [UADDR_W-1:0] io_ea_branch(input logic [WORD_W-1:0] ir);
        if (ir[WORD_W-1:WORD_W-3] == 3'b011) begin
            io_ea_branch = UA_IO_BASE | {5'b0_0000, ir[WORD_W-6 -: 3]};
        end else begin
            io_ea_branch = UA_EA_BASE | {5'b0_0000, ir[WORD_W-4 -: 3]};
        end
    endfunction
    logic [UADDR_W-1:0] start_address_generator;
    always_comb begin
        if (refresh_nmi_req) begin
            start_address_generator = UA_REFRESH;
        end else if (data_channel_req) begin
            start_address_generator = UA_DCH;
        end else if (io_interrupt_req) begin
            start_address_generator = UA_INTR;
        end else if (instruction[WORD_W-1]) begin
            start_address_generator = UA_INSTR;
        end else begin
            start_address_generator = io_ea_branch(instruction);
        end
    end
    // sequencer advances once per microcycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            uaddr_r <= UA_RESET;
        end else if (step_b) begin
            uaddr_r <= seq_end ? start_address_generator : branch_addr;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            micro_address <= UA_RESET;
        end else begin
            micro_address <= uaddr_r;
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            instruction <= '0;
        end else if (step_b && seq_end) begin
            instruction <= fetch_src;
        end
    end

    // checks
    sequence s_a_load;
        phase_end && phase_r == PH_A;
    endsequence
    a_phase_complement: assert property (@(posedge clk) disable iff (!rst_n)
        microcycle_phase_a_clock != microcycle_phase_b_clock) else $error("phases equal");
    a_phase_length: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(microcycle_phase_a_clock) |=> microcycle_phase_a_clock[*2]) else $error("phase short");
    a_fast_invert: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n) |-> fast_system_clock != $past(fast_s2_r)) else $error("fast not inverted");
    a_refresh_first: assert property (@(posedge clk) disable iff (!rst_n)
        step_b && seq_end && refresh_nmi_req |=> uaddr_r == UA_REFRESH) else $error("nmi lost");
    a_dch_before_int: assert property (@(posedge clk) disable iff (!rst_n)
        step_b && seq_end && !refresh_nmi_req && data_channel_req |=> uaddr_r == UA_DCH)
        else $error("priority");
    a_branch_take: assert property (@(posedge clk) disable iff (!rst_n)
        step_b && !seq_end |=> uaddr_r == $past(branch_addr)) else $error("branch");
    a_b_after_a: assert property (@(posedge clk) disable iff (!rst_n)
        s_a_load ##1 1'b1 |-> ##(PHASE_CYCLES-1) phase_r == PH_B && phase_end) else $error("b late");
    a_rf_write_b: assert property (@(posedge clk) disable iff (!rst_n)
        step_b && rf_we |=> rf_mem[$past(port_b_select)] == $past(alu_y)) else $error("rf write");
    a_row_count: assert property (@(posedge clk) disable iff (!rst_n)
        battery_backup && refresh_row_step |=> memory_address_bus[ROW_W-1:0]
        == $past(memory_address_bus[ROW_W-1:0]) + ROW_W'(1)) else $error("row count");
    a_b_half_load: assert property (@(posedge clk) disable iff (!rst_n)
        step_b |=> micro_register_b == $past(control_store_bus)) else $error("b half");
    a_alc_overwrite: assert property (@(posedge clk) disable iff (!rst_n)
        s_a_load ##0 alc_active |=>
        micro_register_a[HALF_W-1 -: 10] == alc_decode($past(instruction))) else $error("alc field");
endmodule
`default_nettype wire

/* File: hdl/ucpu_pkg.sv */
// constants and types shared by the microcoded control and datapath block
`default_nettype none
package ucpu_pkg;
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned MICROCYCLE_NS = 200;
    localparam int unsigned PHASE_NS      = 100;
    localparam int unsigned PHASE_CYCLES  = (PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PCNT_W        = 2;
    localparam logic [PCNT_W-1:0] PHASE_LAST = PCNT_W'(PHASE_CYCLES - 1);
    localparam int unsigned WORD_W  = 16;
    localparam int unsigned HALF_W  = 24;
    localparam int unsigned UADDR_W = 8;
    localparam int unsigned CS_ADDR_W = 9;
    localparam int unsigned CS_DEPTH  = 512;
    localparam int unsigned ROM_W     = 8;
    localparam int unsigned ROMS_PER_PAGE = 3;
    localparam int unsigned SLICE_W = 4;
    localparam int unsigned SLICES  = 4;
    localparam int unsigned RF_DEPTH = 16;
    localparam int unsigned SEL_W    = 4;
    localparam int unsigned MADDR_W  = 15;
    localparam int unsigned SPAD_AW  = 4;
    localparam int unsigned ROW_W    = 6;
    localparam int unsigned TEST_W   = 4;
    // a-half fields
    localparam int unsigned A_OP_LO  = 14;
    localparam int unsigned A_OP_HI  = 22;
    localparam int unsigned A_ALC_LO = 14;
    localparam int unsigned A_SELA_LO = 0;
    localparam int unsigned A_SELB_LO = 4;
    localparam int unsigned A_WE_BIT  = 8;
    localparam int unsigned A_RMUX_BIT = 9;
    localparam int unsigned A_SMUX_LO  = 10;
    localparam int unsigned A_DST_LO   = 12;
    // b-half fields
    localparam int unsigned B_TRUE_LO  = 0;
    localparam int unsigned B_FALSE_LO = 8;
    localparam int unsigned B_TEST_LO  = 16;
    localparam int unsigned B_ALC_BIT  = 20;
    // instruction bits (bit 0 is msb)
    localparam int unsigned IR_ALC_LO = 5;
    localparam int unsigned IR_ALC_HI = 9;
    localparam int unsigned IR_ALC_X  = 12;
    // fixed microaddresses
    localparam logic [UADDR_W-1:0] UA_RESET   = 8'h00;
    localparam logic [UADDR_W-1:0] UA_REFRESH = 8'h04;
    localparam logic [UADDR_W-1:0] UA_DCH     = 8'h08;
    localparam logic [UADDR_W-1:0] UA_INTR    = 8'h0C;
    localparam logic [UADDR_W-1:0] UA_INSTR   = 8'h10;
    localparam logic [UADDR_W-1:0] UA_IO_BASE = 8'h40;
    localparam logic [UADDR_W-1:0] UA_EA_BASE = 8'h80;
    localparam logic [UADDR_W-1:0] UA_END     = 8'hFF;
    localparam logic [HALF_W-1:0]  UI_NOP     = 24'h00_0000;
    typedef enum logic [1:0] {PH_A = 2'b00, PH_B = 2'b01} phase_t;
    typedef enum logic [1:0] {DST_NONE = 2'b00, DST_MAR = 2'b01,
                              DST_WDR = 2'b10, DST_SPAD = 2'b11} dst_t;
    typedef enum logic [3:0] {T_TRUE = 4'h0, T_ZERO = 4'h1, T_CARRY = 4'h2,
                              T_NEG = 4'h3, T_CONSOLE = 4'h4, T_IOREADY = 4'h5,
                              T_FALSE = 4'hF} test_t;
endpackage
`default_nettype wire

/* File: test/far_side_model.sv */
// far-side model: main memory and virtual console answering fetches
`default_nettype none
module far_side_model
    import ucpu_pkg::*;
(
    input  wire logic              clk,
    input  wire logic [WORD_W-1:0] mem_word,
    input  wire logic [WORD_W-1:0] con_word,
    output logic [WORD_W-1:0]      memory_read_bus,
    output logic [WORD_W-1:0]      console_read_bus,
    output logic                   io_ready
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [1:0] slow_r = 2'h0;

    // every memory word holds the same instruction, so any fetch address returns it
    assign memory_read_bus  = mem_word;
    assign console_read_bus = con_word;

    // io devices are slow: ready only one cycle in four
    always_ff @(posedge clk) begin
        slow_r <= slow_r + 2'h1;
    end
    assign io_ready = (slow_r == 2'h3);
endmodule
`default_nettype wire

/* File: test/microcoded_cpu_control_datapath_bench.sv */
// self-checking bench for the microcoded control and datapath block
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module microcoded_cpu_control_datapath_bench import ucpu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [HALF_W-1:0] A_MARK = 24'h00_0055;
    logic                 clk = 1'b0;
    logic                 rst_n = 1'b0;
    logic                 board_fast_input_clock = 1'b0;
    logic                 data_channel_req = 1'b0;
    logic                 io_interrupt_req = 1'b0;
    logic                 refresh_nmi_req = 1'b0;
    logic                 console_mode = 1'b0;
    logic                 battery_backup = 1'b0;
    logic                 refresh_row_step = 1'b0;
    logic                 io_ready;
    logic [WORD_W-1:0]    memory_read_bus, console_read_bus, write_data_bus, alu_result_bus;
    logic [WORD_W-1:0]    mem_word = 16'h8000;
    logic [WORD_W-1:0]    con_word = 16'h0000;
    logic                 cs_load_en = 1'b0;
    logic [CS_ADDR_W-1:0] cs_load_addr = 9'h000;
    logic [HALF_W-1:0]    cs_load_data = 24'h00_0000;
    logic                 fast_system_clock, microcycle_phase_a_clock, microcycle_phase_b_clock;
    logic [MADDR_W-1:0]   memory_address_bus;
    logic [UADDR_W-1:0]   micro_address;
    logic [HALF_W-1:0]    micro_register_a, micro_register_b;
    logic [WORD_W-1:0]    instruction, read_data;
    int                   n_checks = 0;
    int                   n_mismatch = 0;
    int                   cycles = 0;

    microcoded_cpu_control_datapath u_microcoded_cpu_control_datapath (
        .clk(clk), .rst_n(rst_n), .board_fast_input_clock(board_fast_input_clock),
        .data_channel_req(data_channel_req), .io_interrupt_req(io_interrupt_req),
        .refresh_nmi_req(refresh_nmi_req), .console_mode(console_mode),
        .battery_backup(battery_backup), .refresh_row_step(refresh_row_step),
        .io_ready(io_ready), .memory_read_bus(memory_read_bus),
        .console_read_bus(console_read_bus), .cs_load_en(cs_load_en),
        .cs_load_addr(cs_load_addr), .cs_load_data(cs_load_data),
        .fast_system_clock(fast_system_clock),
        .microcycle_phase_a_clock(microcycle_phase_a_clock),
        .microcycle_phase_b_clock(microcycle_phase_b_clock),
        .memory_address_bus(memory_address_bus), .write_data_bus(write_data_bus),
        .alu_result_bus(alu_result_bus), .micro_address(micro_address),
        .micro_register_a(micro_register_a), .micro_register_b(micro_register_b),
        .instruction(instruction), .read_data(read_data));

    far_side_model u_far_side_model (
        .clk(clk), .mem_word(mem_word), .con_word(con_word),
        .memory_read_bus(memory_read_bus), .console_read_bus(console_read_bus),
        .io_ready(io_ready));

    // 40 ns period, 25 MHz
    always #20 clk = ~clk;

    // a hang is cut short well beyond the roughly 1200 cycles the tests need at most
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_sim();
        end
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // bounded wait for the sequencer to present a given microaddress
    task automatic wait_addr(input logic [UADDR_W-1:0] a, output logic hit);
        hit = 1'b0;
        for (int k = 0; k < 80 && !hit; k++) begin
            step(1);
            hit = (micro_address === a);
        end
    endtask

    task automatic check_reset();
        `CHK(micro_address, UA_RESET)
        `CHK(micro_register_a, UI_NOP)
        `CHK(micro_register_b, UI_NOP)
        `CHK({microcycle_phase_a_clock, microcycle_phase_b_clock}, 2'b10)
    endtask

    // every word ends its sequence; 0x10 tests false and branches to 0x20
    task automatic load_store();
        logic [HALF_W-1:0] d;
        cs_load_en = 1'b1;
        for (int i = 0; i < CS_DEPTH; i++) begin
            d = i[0] ? {4'h0, T_TRUE, 8'hFF, UA_END} : UI_NOP;
            if (i == 32) d = A_MARK;
            if (i == 33) d = {4'h0, T_FALSE, 8'h20, UA_END};
            if (i == 262) d = 24'h04_2310; // 0x83: pass read data to wdr and entry 1
            if (i == 139) d = 24'h10_FFFF; // 0x45: alc decode on the following fetch
            cs_load_addr = CS_ADDR_W'(i);
            cs_load_data = d;
            step(1);
        end
        cs_load_en = 1'b0;
    endtask

    task automatic t_clocks();
        int hi;
        hi = 0;
        for (int k = 0; k < 12; k++) begin
            `CHK(microcycle_phase_b_clock, ~microcycle_phase_a_clock)
            hi += int'(microcycle_phase_a_clock === 1'b1);
            step(1);
        end
        `CHK(hi, 6)
        board_fast_input_clock = 1'b1;
        step(6);
        `CHK(fast_system_clock, 1'b0)
        board_fast_input_clock = 1'b0;
        step(6);
        `CHK(fast_system_clock, 1'b1)
        $display("done: clocks");
    endtask

    task automatic t_prio();
        logic hit;
        refresh_nmi_req = 1'b1;
        data_channel_req = 1'b1;
        io_interrupt_req = 1'b1;
        wait_addr(UA_REFRESH, hit);
        `CHK(hit, 1'b1)
        refresh_nmi_req = 1'b0;
        wait_addr(UA_DCH, hit);
        `CHK(hit, 1'b1)
        data_channel_req = 1'b0;
        wait_addr(UA_INTR, hit);
        `CHK(hit, 1'b1)
        io_interrupt_req = 1'b0;
        hit = 1'b0;
        for (int k = 0; k < 80 && !hit; k++) begin
            step(1);
            hit = (micro_register_a === A_MARK);
        end
        `CHK(hit, 1'b1)
        step(3);
        `CHK(micro_register_b, {4'h0, T_FALSE, 8'h20, UA_END})
        wait_addr(8'h20, hit);
        `CHK(hit, 1'b1)
        $display("done: priority and branching");
    endtask

    task automatic t_decode();
        logic hit;
        mem_word = 16'h6300;
        wait_addr(UA_IO_BASE | 8'h03, hit);
        `CHK(hit, 1'b1)
        mem_word = 16'h0C00;
        wait_addr(UA_EA_BASE | 8'h03, hit);
        `CHK(hit, 1'b1)
        step(6);
        `CHK(read_data, 16'h0C00)
        `CHK(alu_result_bus, 16'h0C00)
        `CHK(write_data_bus, 16'h0C00)
        con_word = 16'h6500;
        console_mode = 1'b1;
        wait_addr(UA_IO_BASE | 8'h05, hit);
        `CHK(hit, 1'b1)
        `CHK(instruction, 16'h6500)
        step(9);
        `CHK(micro_register_a[HALF_W-1 -: 10], 10'h284)
        console_mode = 1'b0;
        $display("done: decode");
    endtask

    // row counter steps once per pulse only while battery backup is on
    task automatic t_rows();
        logic [5:0] r;
        battery_backup = 1'b1;
        step(2);
        r = memory_address_bus[5:0];
        for (int k = 0; k < 3; k++) begin
            refresh_row_step = 1'b1;
            step(1);
            refresh_row_step = 1'b0;
            step(1);
        end
        step(1);
        `CHK(memory_address_bus[5:0], r + 6'h03)
        battery_backup = 1'b0;
        $display("done: refresh rows");
    endtask

    initial begin
        step(16);
        check_reset();
        // store filled under reset so the first fetch never reads unwritten words
        load_store();
        check_reset();
        rst_n = 1'b1;
        t_clocks();
        rst_n = 1'b0;
        step(16);
        check_reset();
        rst_n = 1'b1;
        t_prio();
        t_decode();
        t_rows();
        end_sim();
    end
endmodule
`default_nettype wire
